// ---- ckg_clock_gen.sv ----
// processor clock, bus clock and dma clock generator
// Behaviour
// R01: processor clock is input clock divided by 1, 2, 3 or 4 per field
// R02: divider applies while speed pin low or after slow-speed command write
// R03: processor divider field resets to 00, undivided clock
// R04: reference oscillator passes through unchanged
// R05: bus strobes change only on bus clock rising edges
// R06: bus oscillator presence sensed during power-on reset sets source and pin role
// R07: strap pins captured into slow divider high and low bits
// R08: slow divider divides source by 2, 4, 6 or 8
// R09: fast divider divides by 2, 4 or 6; code 11 undefined
// R10: without oscillator, pin low selects slow divider, high selects fast
// R11: video range switching forces fast divider during video range access
// R12: video range switching enable resets to 0
// R13: without oscillator, sense bit reads pin level and is read-only
// R14: with oscillator, bus clock derived from bus oscillator
// R15: with oscillator, sense bit writable; 1 or video access selects fast
// R16: with oscillator, start on slow divider per strapped code
// R17: dma clock is bus clock when select 1, half bus clock when 0
// R18: dma clock select resets to 0
// R19: divider switches only at phase boundaries, no short phases; processor divider switches mid phase on speed pin or slow command
`timescale 1ns/1ps
module ckg_clock_gen (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic crystal_clock_input,
  input wire logic reference_osc_in,
  output logic reference_oscillator_out,
  input wire logic bus_oscillator_input,
  input wire logic strap_pin_high_bit,
  input wire logic strap_pin_low_bit,
  input wire logic speed_select,
  input wire logic slow_cmd_wr,
  input wire ckg_pkg::ckg_wr_s cfg_wr,
  input wire logic [7:0] cfg_rd_idx,
  output logic [7:0] cfg_rd_data,
  input wire logic mem_access,
  input wire logic [6:0] mem_addr_hi,
  input wire logic [3:0] bus_cmd_req,
  output logic [3:0] bus_cmd_out,
  output logic bus_ale_out,
  input wire logic bus_ale_req,
  output logic processor_clock,
  output logic at_bus_clock,
  output logic dma_clock
);
  typedef enum logic [1:0] {ST_SENSE, ST_RUN} ckg_state_e;
  typedef struct packed {
    ckg_state_e st;
    logic [8:0] sense_cnt;
    logic [3:0] edge_cnt;
    logic osc_present;
    logic video_en;
    logic [1:0] cpu_div;
    logic [1:0] fast_div;
    logic sense_sel;
    logic [1:0] slow_div;
    logic [7:0] ext_dma;
    logic slow_mode;
    logic src_d;
    logic bosc_d;
    logic [1:0] cpu_cnt;
    logic cpu_clk;
    logic [1:0] cpu_cur;
    logic [2:0] bus_cnt;
    logic [2:0] bus_half;
    logic bus_clk;
    logic dma_half;
    logic dma_clk;
    logic [3:0] cmd;
    logic ale;
    logic xtal_d;
    logic spd_d;
    logic slow_hold;
  } ckg_state_s;

  ckg_state_s s_r;
  ckg_state_s s_nxt;
  logic src_lvl;
  logic src_rise;
  logic use_fast;
  logic bus_tick;
  logic [2:0] half_len;

  // half period of bus clock in source edges for divider code
  function automatic logic [2:0] ckg_half(input logic [1:0] code);
    ckg_half = {1'b0, code} + 3'h1; // R08 R09
  endfunction : ckg_half

  assign reference_oscillator_out = reference_osc_in; // R04
  // source select: bus oscillator when present else crystal clock
  assign src_lvl = s_r.osc_present ? bus_oscillator_input : crystal_clock_input; // R14
  assign src_rise = src_lvl && !s_r.src_d;
  // fast select from pin or sense bit, plus video range speedup
  assign use_fast = (s_r.osc_present ? s_r.sense_sel : bus_oscillator_input) // R10 R15
                    || (s_r.video_en && mem_access && mem_addr_hi == ckg_pkg::VIDEO_PAGE); // R11
  // half length of the bus clock phase about to start
  assign half_len = ckg_half(use_fast ? s_r.fast_div : s_r.slow_div); // R08 R09
  assign bus_tick = src_rise && (s_r.bus_cnt + 3'h1 >= s_r.bus_half);

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.src_d = src_lvl;
    s_nxt.bosc_d = bus_oscillator_input;
    unique case (s_r.st)
      ST_SENSE: begin
        // count pin edges to detect a running oscillator
        if (bus_oscillator_input && !s_r.bosc_d && s_r.edge_cnt != 4'hf) begin
          s_nxt.edge_cnt = s_r.edge_cnt + 4'h1;
        end
        s_nxt.sense_cnt = s_r.sense_cnt + 9'h1;
        if (s_r.sense_cnt == 9'(ckg_pkg::SENSE_CYCLES - 1)) begin
          s_nxt.osc_present = s_r.edge_cnt >= ckg_pkg::SENSE_EDGES; // R06
          s_nxt.slow_div = {strap_pin_high_bit, strap_pin_low_bit}; // R07
          s_nxt.slow_mode = 1'b1; // R16
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cfg_wr.wr && cfg_wr.idx == ckg_pkg::IDX_CLOCK_CFG) begin
          s_nxt.video_en = cfg_wr.data[ckg_pkg::VIDEO_EN_BIT];
          s_nxt.cpu_div = cfg_wr.data[ckg_pkg::CPU_DIV_LSB +: 2];
          s_nxt.fast_div = cfg_wr.data[ckg_pkg::FAST_DIV_LSB +: 2];
          s_nxt.slow_div = cfg_wr.data[ckg_pkg::SLOW_DIV_LSB +: 2];
          if (s_r.osc_present) begin
            s_nxt.sense_sel = cfg_wr.data[ckg_pkg::SENSE_BIT]; // R13 R15
          end
        end
        if (cfg_wr.wr && cfg_wr.idx == ckg_pkg::IDX_EXT_DMA) begin
          s_nxt.ext_dma = cfg_wr.data;
        end
        // bus clock divider; mode changes only at a phase boundary
        if (src_rise) begin
          s_nxt.bus_cnt = s_r.bus_cnt + 3'h1;
          if (bus_tick) begin
            s_nxt.bus_cnt = 3'h0;
            s_nxt.bus_clk = !s_r.bus_clk;
            s_nxt.slow_mode = !use_fast; // R19
            s_nxt.bus_half = half_len; // R19
            if (!s_r.bus_clk) begin
              s_nxt.cmd = bus_cmd_req; // R05
              s_nxt.ale = bus_ale_req; // R05
              s_nxt.dma_half = !s_r.dma_half;
            end
            s_nxt.dma_clk = s_r.ext_dma[ckg_pkg::DMA_CLK_BIT] ? !s_r.bus_clk // R17
                            : (s_r.bus_clk ? s_r.dma_clk : !s_r.dma_half);
          end
        end
      end
      default: s_nxt.st = ST_SENSE;
    endcase
    // processor divider: toggle after cpu_cur + 1 crystal edges, both edges counted
    s_nxt.xtal_d = crystal_clock_input;
    if (crystal_clock_input != s_r.xtal_d) begin
      if (s_r.cpu_cnt >= s_r.cpu_cur) begin // R01
        s_nxt.cpu_cnt = 2'h0;
        s_nxt.cpu_clk = !s_r.cpu_clk;
      end else begin
        s_nxt.cpu_cnt = s_r.cpu_cnt + 2'h1;
      end
    end
    // slow command holds the divider until the speed pin rises again; set wins
    s_nxt.spd_d = speed_select;
    if (speed_select && !s_r.spd_d) begin
      s_nxt.slow_hold = 1'b0;
    end
    if (slow_cmd_wr) begin
      s_nxt.slow_hold = 1'b1; // R02
    end
    if (!speed_select || s_r.slow_hold || slow_cmd_wr) begin
      s_nxt.cpu_cur = s_r.cpu_div; // R02
    end else begin
      s_nxt.cpu_cur = 2'h0;
    end
  end

  // undivided crystal passes straight through; other codes use the edge counter
  assign processor_clock = (s_r.cpu_cur == 2'h0) ? crystal_clock_input : s_r.cpu_clk; // R01 R03

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.st <= ST_SENSE;
      s_r.cpu_div <= ckg_pkg::CPU_DIV_RST; // R03
      s_r.fast_div <= ckg_pkg::FAST_DIV_RST;
      s_r.video_en <= 1'b0; // R12
      s_r.ext_dma <= ckg_pkg::EXT_DMA_RST; // R18
      s_r.bus_half <= 3'h1;
      s_r.spd_d <= 1'b1; // idle pin level, so no false edge after reset
    end else begin
      s_r <= s_nxt;
    end
  end

  assign at_bus_clock = s_r.bus_clk;
  assign dma_clock = s_r.dma_clk;
  assign bus_cmd_out = s_r.cmd;
  assign bus_ale_out = s_r.ale;

  // register read mux; sense bit reads pin level without oscillator
  always_comb begin
    cfg_rd_data = 8'h00;
    if (cfg_rd_idx == ckg_pkg::IDX_CLOCK_CFG) begin
      cfg_rd_data = {s_r.video_en, s_r.cpu_div, s_r.fast_div,
                     s_r.osc_present ? s_r.sense_sel : bus_oscillator_input, // R13
                     s_r.slow_div};
    end else if (cfg_rd_idx == ckg_pkg::IDX_EXT_DMA) begin
      cfg_rd_data = s_r.ext_dma;
    end
  end

  // reset values, pass-through, strap capture and divider switching checks
  a_cpu_reset: assert property (@(posedge ref_clk) $rose(resetn) |-> s_r.cpu_div == 2'h0) // R03
    else $error("processor divider not cleared at reset");
  a_dma_reset: assert property (@(posedge ref_clk) $rose(resetn) |-> !s_r.ext_dma[1]) // R18
    else $error("dma select not cleared at reset");
  a_video_reset: assert property (@(posedge ref_clk) $rose(resetn) |-> !s_r.video_en) // R12
    else $error("video enable not cleared at reset");
  a_ref_pass: assert property (@(posedge ref_clk) disable iff (!resetn) // R04
    reference_oscillator_out == reference_osc_in)
    else $error("reference oscillator altered");
  a_sense_ro: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
    (s_r.st == ST_RUN && !s_r.osc_present) |-> cfg_rd_idx != ckg_pkg::IDX_CLOCK_CFG
    || cfg_rd_data[ckg_pkg::SENSE_BIT] == bus_oscillator_input)
    else $error("sense bit does not follow pin");
  a_strap_cap: assert property (@(posedge ref_clk) disable iff (!resetn) // R07 R16
    (s_r.st == ST_SENSE && s_nxt.st == ST_RUN) |=>
    s_r.slow_div == $past({strap_pin_high_bit, strap_pin_low_bit}) && s_r.slow_mode)
    else $error("straps not captured");
  a_cmd_sync: assert property (@(posedge ref_clk) disable iff (!resetn) // R05
    $changed({bus_ale_out, bus_cmd_out}) |-> $rose(at_bus_clock))
    else $error("bus command changed off bus clock edge");
  a_mode_edge: assert property (@(posedge ref_clk) disable iff (!resetn) // R19
    $changed(s_r.slow_mode) && s_r.st == ST_RUN && $past(s_r.st) == ST_RUN
    |-> $changed(at_bus_clock))
    else $error("divider switched mid phase");
  a_dma_full: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
    (s_r.ext_dma[1] && $past(s_r.ext_dma[1]) && $changed(at_bus_clock))
    |=> dma_clock == at_bus_clock)
    else $error("dma clock not following bus clock");
endmodule : ckg_clock_gen

// ---- ckg_clock_gen_tb.sv ----
// self-checking bench for the processor, bus and dma clock generator
`timescale 1ns/1ps
module ckg_clock_gen_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic osc_on = 1'b0;
  logic pin_lvl = 1'b0;
  logic ref_in = 1'b0;
  logic spd = 1'b1;
  logic slow_cmd = 1'b0;
  ckg_pkg::ckg_wr_s cfg_wr = '0;
  logic [7:0] rd_idx = 8'h00;
  logic mem_acc = 1'b0;
  logic [6:0] addr_hi = 7'h00;
  logic [3:0] cmd_req = 4'h0;
  logic ale_req = 1'b0;
  logic strap_hi = 1'b1;
  logic strap_lo = 1'b0;
  logic xtal, bosc, ref_out, ale_out, cpu_clk, bus_clk, dma_clk;
  logic [7:0] rd_data;
  logic [3:0] cmd_out;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #4 ref_clk = ~ref_clk;
  ckg_src_model i_src (.ref_clk(ref_clk), .osc_on(osc_on), .pin_lvl(pin_lvl),
    .crystal_clock_input(xtal), .bus_oscillator_input(bosc));
  ckg_clock_gen i_dut (.ref_clk(ref_clk), .resetn(resetn), .crystal_clock_input(xtal),
    .reference_osc_in(ref_in), .reference_oscillator_out(ref_out),
    .bus_oscillator_input(bosc), .strap_pin_high_bit(strap_hi), .strap_pin_low_bit(strap_lo),
    .speed_select(spd), .slow_cmd_wr(slow_cmd), .cfg_wr(cfg_wr), .cfg_rd_idx(rd_idx),
    .cfg_rd_data(rd_data), .mem_access(mem_acc), .mem_addr_hi(addr_hi),
    .bus_cmd_req(cmd_req), .bus_cmd_out(cmd_out), .bus_ale_out(ale_out),
    .bus_ale_req(ale_req), .processor_clock(cpu_clk), .at_bus_clock(bus_clk),
    .dma_clock(dma_clk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // cycles between the 2nd and 3rd rising edge of clock s (0 bus, 1 cpu, 2 dma)
  task automatic pchk(input int s, input int exp);
    logic [2:0] c;
    logic p;
    int k, n, g;
    p = 1'b1;
    k = 0;
    n = 0;
    g = 0;
    while (k < 3 && g < 600) begin
      @(negedge ref_clk);
      c = {dma_clk, cpu_clk, bus_clk} >> s;
      n++;
      g++;
      if (c[0] === 1'b1 && p === 1'b0) begin
        k++;
        if (k < 3) n = 0;
      end
      p = c[0];
    end
    chk(n, exp);
  endtask : pchk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr <= '{wr: 1'b1, idx: idx, data: d};
    @(posedge ref_clk);
    cfg_wr.wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_idx <= idx;
    @(negedge ref_clk);
    chk({24'h0, rd_data}, {24'h0, exp});
  endtask : rdchk
  task automatic do_reset(input logic osc);
    @(posedge ref_clk);
    resetn <= 1'b0;
    osc_on <= osc;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (ckg_pkg::SENSE_CYCLES + 20) @(posedge ref_clk);
  endtask : do_reset
  // reset values, straps 1/0 give slow code 10, dma at half bus clock
  task automatic t_reset();
    rdchk(ckg_pkg::IDX_CLOCK_CFG, 8'h12);
    rdchk(ckg_pkg::IDX_EXT_DMA, ckg_pkg::EXT_DMA_RST);
    pchk(0, 24);
    pchk(2, 48);
  endtask : t_reset
  // pin high picks fast divider; strobes follow the bus clock
  task automatic t_fast();
    @(posedge ref_clk);
    pin_lvl <= 1'b1;
    pchk(0, 24);
    rdchk(ckg_pkg::IDX_CLOCK_CFG, 8'h16);
    wr(ckg_pkg::IDX_CLOCK_CFG, 8'h02);
    pchk(0, 8);
    wr(ckg_pkg::IDX_EXT_DMA, ckg_pkg::EXT_DMA_RST | 8'h02);
    pchk(2, 8);
    @(posedge ref_clk);
    cmd_req <= 4'h5;
    ale_req <= 1'b1;
    pchk(0, 8);
    chk({27'h0, ale_out, cmd_out}, 32'h15);
    @(posedge ref_clk);
    pin_lvl <= 1'b0;
    pchk(0, 24);
  endtask : t_fast
  // sense bit stays read-only without an oscillator; video range speeds up
  task automatic t_video();
    wr(ckg_pkg::IDX_CLOCK_CFG, 8'h06);
    rdchk(ckg_pkg::IDX_CLOCK_CFG, 8'h02);
    wr(ckg_pkg::IDX_CLOCK_CFG, 8'h82);
    mem_acc <= 1'b1;
    addr_hi <= ckg_pkg::VIDEO_PAGE;
    pchk(0, 8);
    @(posedge ref_clk);
    addr_hi <= 7'h06;
    pchk(0, 24);
    @(posedge ref_clk);
    mem_acc <= 1'b0;
  endtask : t_video
  // every processor divider code, applied with speed pin low or after slow command
  task automatic t_cpu();
    for (int c = 0; c < 4; c++) begin
      wr(ckg_pkg::IDX_CLOCK_CFG, {1'b0, c[1:0], 5'h02});
      spd <= 1'b0;
      pchk(1, 4 * (c + 1));
      @(posedge ref_clk);
      spd <= 1'b1;
      pchk(1, 4);
    end
    @(posedge ref_clk);
    slow_cmd <= 1'b1;
    @(posedge ref_clk);
    slow_cmd <= 1'b0;
    pchk(1, 16);
    // a rising speed pin returns the processor clock to full speed
    @(posedge ref_clk);
    spd <= 1'b0;
    @(posedge ref_clk);
    spd <= 1'b1;
    pchk(1, 4);
    @(posedge ref_clk);
    ref_in <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, ref_out}, 32'h1);
  endtask : t_cpu
  // fitted oscillator: straps 0/1 give slow code 01, then sense bit selects fast
  task automatic t_osc();
    @(posedge ref_clk);
    strap_hi <= 1'b0;
    strap_lo <= 1'b1;
    do_reset(1'b1);
    rdchk(ckg_pkg::IDX_CLOCK_CFG, 8'h11);
    pchk(0, 24);
    wr(ckg_pkg::IDX_CLOCK_CFG, 8'h06);
    rdchk(ckg_pkg::IDX_CLOCK_CFG, 8'h06);
    pchk(0, 12);
  endtask : t_osc
  task automatic report_and_stop();
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    do_reset(1'b0);
    t_reset();
    t_fast();
    t_video();
    t_cpu();
    t_osc();
    report_and_stop();
  end
endmodule : ckg_clock_gen_tb

// ---- ckg_pkg.sv ----
// package for the processor and bus clock generator
package ckg_pkg;
  // indexed configuration port and register indices
  localparam logic [7:0] IDX_CLOCK_CFG = 8'h07;
  localparam logic [7:0] IDX_EXT_DMA = 8'h15;
  // clock config field positions
  localparam int VIDEO_EN_BIT = 7;
  localparam int CPU_DIV_LSB = 5;
  localparam int FAST_DIV_LSB = 3;
  localparam int SENSE_BIT = 2;
  localparam int SLOW_DIV_LSB = 0;
  // extended dma config field positions
  localparam int DMA_CLK_BIT = 1;
  // reset values
  localparam logic [1:0] CPU_DIV_RST = 2'h0;
  localparam logic [1:0] FAST_DIV_RST = 2'h2;
  localparam logic [7:0] EXT_DMA_RST = 8'h38;
  // video memory range, top address bits a23..a17 (a0000h-bffffh)
  localparam logic [6:0] VIDEO_PAGE = 7'h05;
  // oscillator sense: edges counted on the pin during the sense window
  localparam int SENSE_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SENSE_CYCLES = SENSE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SENSE_EDGES = 4'h4;

  // register write strobe group
  typedef struct packed {
    logic wr;
    logic [7:0] idx;
    logic [7:0] data;
  } ckg_wr_s;
endpackage : ckg_pkg

// ---- ckg_src_model.sv ----
// source model: crystal clock and bus oscillator pin seen by the generator
`timescale 1ns/1ps
module ckg_src_model (
  input wire logic ref_clk,
  input wire logic osc_on,
  input wire logic pin_lvl,
  output logic crystal_clock_input,
  output logic bus_oscillator_input
);
  logic [1:0] xc_r = 2'h0;
  logic [1:0] oc_r = 2'h0;
  logic xtal_r = 1'b0;
  logic bosc_r = 1'b0;
  assign crystal_clock_input = xtal_r;
  assign bus_oscillator_input = bosc_r;
  // crystal toggles every 2 cycles; fitted oscillator every 3, else pin held at a level
  always @(posedge ref_clk) begin
    xc_r <= xc_r + 2'h1;
    oc_r <= (oc_r == 2'h2) ? 2'h0 : oc_r + 2'h1;
    if (xc_r[0]) begin
      xtal_r <= ~xtal_r;
    end
    if (!osc_on) begin
      bosc_r <= pin_lvl;
    end else if (oc_r == 2'h2) begin
      bosc_r <= ~bosc_r;
    end
  end
endmodule : ckg_src_model
